// *** verilog/iod_io_register_space_decoder.sv ***
// Low I/O register space decoder: storage and decode for I/O 0x00..0x3f, bit access for 0x00..0x1f.
// Assumes the core issues one request at a time and waits for resp.valid before the next.
// Behaviour
// - Bit set and clear on low range.
// - Bit test with skip on low range.
// - Status flags clear on written one.
// - Bit operations touch only the addressed bit.
// - Bit operations limited to locations 0x00..0x1f.
// - Dedicated I/O access uses addresses 0x00..0x3f.
// - Data-space access adds offset 0x20.
// - Dedicated I/O address field spans 64 locations.
// - Extended range reachable only by data access.
`timescale 1ns/1ps

module iod_io_register_space_decoder
  import iod_pkg::*;
#(
  parameter int IO_LOCS = IOD_IO_LOCS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Core request and answer
  input iod_req_t req,
  output iod_resp_t resp,
  // Extended I/O forwarding
  output iod_ext_t ext,
  input wire logic [7:0] extRdata,
  // Peripheral side
  input iod_pins_t pinsIn,
  input wire logic [63:0][7:0] hwSet,
  input wire logic [63:0][7:0] hwLevel,
  output logic [63:0][7:0] regImage
);

  // Elaboration check: the opcode field only serves 64 locations
  if (IO_LOCS != IOD_IO_LOCS) begin : g_bad_locs
    $error("IO_LOCS must be 64");
  end

  // Writable bits per I/O location
  function automatic logic [7:0] rwMask(input logic [5:0] idx);
    logic [7:0] m;
    m = IOD_MASK_NONE;
    case (idx)
      IOD_PORT_B_DIRECTION, IOD_PORT_B_OUTPUT: m = IOD_MASK_FULL;
      IOD_PORT_C_DIRECTION, IOD_PORT_C_OUTPUT: m = IOD_MASK_PORT_C;
      IOD_PORT_D_DIRECTION, IOD_PORT_D_OUTPUT: m = IOD_MASK_FULL;
      IOD_EXTERNAL_IRQ_MASK: m = IOD_MASK_EXT_IRQ;
      IOD_GENERAL_SCRATCH_0, IOD_GENERAL_SCRATCH_1, IOD_GENERAL_SCRATCH_2: m = IOD_MASK_FULL;
      IOD_NVM_CONTROL: m = IOD_MASK_NVM_CONTROL;
      IOD_NVM_DATA, IOD_NVM_ADDRESS_LOW, IOD_NVM_ADDRESS_HIGH: m = IOD_MASK_FULL;
      IOD_GENERAL_TIMER_CONTROL: m = IOD_MASK_GEN_TIMER;
      IOD_TIMER0_CONTROL_A: m = IOD_MASK_TIMER0_CTL_A;
      IOD_TIMER0_CONTROL_B: m = IOD_MASK_TIMER0_CTL_B;
      IOD_TIMER0_COUNT, IOD_TIMER0_COMPARE_A, IOD_TIMER0_COMPARE_B: m = IOD_MASK_FULL;
      IOD_SERIAL_PERIPH_CONTROL, IOD_SERIAL_PERIPH_DATA: m = IOD_MASK_FULL;
      IOD_SERIAL_PERIPH_STATUS: m = IOD_MASK_SPI_STATUS_RW;
      IOD_COMPARATOR_CONTROL_STATUS: m = IOD_MASK_COMP_RW;
      IOD_SLEEP_CONTROL, IOD_RESET_CAUSE_STATUS: m = IOD_MASK_LOW_NIBBLE;
      IOD_CORE_CONTROL: m = IOD_MASK_CORE_CTL;
      default: m = IOD_MASK_NONE;
    endcase
    return m;
  endfunction

  // Write-one-to-clear flag bits per I/O location
  function automatic logic [7:0] w1cMask(input logic [5:0] idx);
    logic [7:0] m;
    m = IOD_MASK_NONE;
    case (idx)
      IOD_TIMER0_FLAGS: m = IOD_MASK_TIMER0_FLAGS;
      IOD_TIMER1_FLAGS: m = IOD_MASK_TIMER1_FLAGS;
      IOD_TIMER2_FLAGS: m = IOD_MASK_TIMER2_FLAGS;
      IOD_PIN_CHANGE_FLAGS: m = IOD_MASK_PIN_CHANGE;
      IOD_EXTERNAL_IRQ_FLAGS: m = IOD_MASK_EXT_IRQ;
      IOD_COMPARATOR_CONTROL_STATUS: m = IOD_MASK_COMP_W1C;
      default: m = IOD_MASK_NONE;
    endcase
    return m;
  endfunction

  // Read-only status bits mirrored from peripheral levels
  function automatic logic [7:0] roMask(input logic [5:0] idx);
    logic [7:0] m;
    m = IOD_MASK_NONE;
    case (idx)
      IOD_SERIAL_PERIPH_STATUS: m = IOD_MASK_SPI_STATUS_RO;
      IOD_COMPARATOR_CONTROL_STATUS: m = IOD_MASK_COMP_RO;
      default: m = IOD_MASK_NONE;
    endcase
    return m;
  endfunction

  // Pin input registers, read-only and fed from synchronised pins
  function automatic logic [7:0] pinMask(input logic [5:0] idx);
    logic [7:0] m;
    m = IOD_MASK_NONE;
    case (idx)
      IOD_PORT_B_PIN_INPUT, IOD_PORT_D_PIN_INPUT: m = IOD_MASK_FULL;
      IOD_PORT_C_PIN_INPUT: m = IOD_MASK_PORT_C;
      default: m = IOD_MASK_NONE;
    endcase
    return m;
  endfunction

  // Every bit that reads back; all else reads zero
  function automatic logic [7:0] implMask(input logic [5:0] idx);
    return rwMask(idx) | w1cMask(idx) | roMask(idx) | pinMask(idx);
  endfunction

  // Registers
  logic [63:0][7:0] ioReg_q;
  logic [63:0][7:0] ioReg_d;
  iod_pins_t pinS1_q;
  iod_pins_t pinS2_q;
  iod_pins_t pinS3_q;
  iod_pins_t pinStable_q;
  iod_pins_t pinStable_d;
  iod_resp_t resp_q;
  iod_resp_t resp_d;
  iod_ext_t ext_q;
  iod_ext_t ext_d;
  iod_state_t state_q;
  iod_state_t state_d;

  // Request classification
  wire isIoOp = (req.kind == IOD_IO_READ) || (req.kind == IOD_IO_WRITE);
  wire isDataOp = (req.kind == IOD_DATA_READ) || (req.kind == IOD_DATA_WRITE);
  wire isSetClr = (req.kind == IOD_SET_IO_BIT) || (req.kind == IOD_CLEAR_IO_BIT);
  wire isSkip = (req.kind == IOD_SKIP_IF_IO_BIT_SET) || (req.kind == IOD_SKIP_IF_IO_BIT_CLEAR);
  wire isBitOp = isSetClr || isSkip;
  wire isRead = (req.kind == IOD_IO_READ) || (req.kind == IOD_DATA_READ);
  wire isWrite = (req.kind == IOD_IO_WRITE) || (req.kind == IOD_DATA_WRITE);
  wire idle = (state_q == IOD_ST_IDLE);
  wire take = req.valid && idle;

  // Address range decode
  wire ioRange = (req.addr <= IOD_IO_TOP);
  wire bitRange = (req.addr <= IOD_BIT_TOP);
  wire dataIoRange = (req.addr >= IOD_DATA_OFS) && (req.addr < IOD_EXT_LO);
  wire dataExtRange = (req.addr >= IOD_EXT_LO);
  wire [7:0] dataIdxFull = req.addr - IOD_DATA_OFS;
  wire [5:0] localIdx = isDataOp ? dataIdxFull[5:0] : req.addr[5:0];

  // Which path serves the request
  wire ioHit = (isIoOp && ioRange) || (isBitOp && bitRange) || (isDataOp && dataIoRange);
  wire extHit = isDataOp && dataExtRange;
  wire localHit = take && ioHit;
  wire refuse = req.valid && (!idle || (!ioHit && !extHit));

  // Operation strobes on the selected location
  wire doWrite = localHit && isWrite;
  wire doSet = localHit && (req.kind == IOD_SET_IO_BIT);
  wire doClr = localHit && (req.kind == IOD_CLEAR_IO_BIT);
  wire [7:0] bitOne = IOD_BIT_ONE << req.bitSel;

  // Value seen by reads and bit tests
  wire [7:0] curVal = ioReg_q[localIdx] & implMask(localIdx);
  wire bitVal = |(curVal & bitOne);
  wire skipHit = (req.kind == IOD_SKIP_IF_IO_BIT_SET) ? bitVal : !bitVal;

  // Pin synchroniser: a change counts once stages two and three agree
  always_comb begin
    pinStable_d = pinStable_q;
    if (pinS2_q == pinS3_q) begin
      pinStable_d = pinS3_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinS1_q <= '0;
      pinS2_q <= '0;
      pinS3_q <= '0;
      pinStable_q <= '0;
    end else begin
      pinS1_q <= pinsIn;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinStable_q <= pinStable_d;
    end
  end

  // Next value of every I/O location
  always_comb begin
    logic [7:0] val;
    logic [7:0] clr;
    logic [7:0] rw;
    logic [7:0] w1c;
    logic [7:0] ro;
    val = IOD_RESET_VALUE;
    clr = IOD_MASK_NONE;
    rw = IOD_MASK_NONE;
    w1c = IOD_MASK_NONE;
    ro = IOD_MASK_NONE;
    for (int i = 0; i < IO_LOCS; i++) begin
      rw = rwMask(i[5:0]);
      w1c = w1cMask(i[5:0]);
      ro = roMask(i[5:0]);
      clr = IOD_MASK_NONE;
      val = (ioReg_q[i] & ~ro) | (hwLevel[i] & ro);
      if (localIdx == i[5:0]) begin
        if (doWrite) begin
          val = (val & ~rw) | (req.wdata & rw);
          clr = req.wdata & w1c;
        end
        if (doSet) begin
          val = val | (bitOne & rw);
          clr = bitOne & w1c;
        end
        if (doClr) begin
          val = val & ~(bitOne & rw);
        end
      end
      // Hardware set wins over a same-cycle clear
      val = (val & ~clr) | (hwSet[i] & w1c);
      ioReg_d[i] = val & implMask(i[5:0]);
    end
    ioReg_d[IOD_PORT_B_PIN_INPUT] = pinStable_q.port_b_output;
    ioReg_d[IOD_PORT_C_PIN_INPUT] = {1'b0, pinStable_q.port_c_output};
    ioReg_d[IOD_PORT_D_PIN_INPUT] = pinStable_q.port_d_output;
  end

  // Answer and extended forwarding
  always_comb begin
    resp_d = '0;
    ext_d = '0;
    state_d = state_q;
    if (state_q == IOD_ST_EXT_WAIT) begin
      resp_d.valid = 1'b1;
      resp_d.data = extRdata;
      state_d = IOD_ST_IDLE;
    end
    if (refuse) begin
      resp_d.valid = 1'b1;
      resp_d.refused = 1'b1;
    end else if (take && extHit) begin
      ext_d.read = isRead;
      ext_d.write = isWrite;
      ext_d.addr = req.addr;
      ext_d.wdata = req.wdata;
      resp_d.valid = isWrite;
      state_d = isRead ? IOD_ST_EXT_WAIT : IOD_ST_IDLE;
    end else if (localHit) begin
      resp_d.valid = 1'b1;
      resp_d.data = (isRead || isSkip) ? curVal : IOD_RESET_VALUE;
      resp_d.skip = isSkip && skipHit;
    end
  end

  // State flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ioReg_q <= '0;
      resp_q <= '0;
      ext_q <= '0;
      state_q <= IOD_ST_IDLE;
    end else begin
      ioReg_q <= ioReg_d;
      resp_q <= resp_d;
      ext_q <= ext_d;
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign resp = resp_q;
  assign ext = ext_q;
  assign regImage = ioReg_q;

endmodule

// *** verilog/iod_pkg.sv ***
// Shared constants, types and carriers for the low I/O register space decoder.
// Assumes one core clock domain; the core talks to the decoder through iod_req_t.
package iod_pkg;

  // Address space limits
  localparam int IOD_IO_LOCS = 64;
  localparam logic [7:0] IOD_IO_TOP = 8'h3f;
  localparam logic [7:0] IOD_BIT_TOP = 8'h1f;
  localparam logic [7:0] IOD_DATA_OFS = 8'h20;
  localparam logic [7:0] IOD_EXT_LO = 8'h60;

  // Register offsets in I/O space
  localparam logic [5:0] IOD_PORT_B_PIN_INPUT = 6'h03;
  localparam logic [5:0] IOD_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] IOD_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] IOD_PORT_C_PIN_INPUT = 6'h06;
  localparam logic [5:0] IOD_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] IOD_PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] IOD_PORT_D_PIN_INPUT = 6'h09;
  localparam logic [5:0] IOD_PORT_D_DIRECTION = 6'h0a;
  localparam logic [5:0] IOD_PORT_D_OUTPUT = 6'h0b;
  localparam logic [5:0] IOD_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] IOD_TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] IOD_TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] IOD_PIN_CHANGE_FLAGS = 6'h1b;
  localparam logic [5:0] IOD_EXTERNAL_IRQ_FLAGS = 6'h1c;
  localparam logic [5:0] IOD_EXTERNAL_IRQ_MASK = 6'h1d;
  localparam logic [5:0] IOD_GENERAL_SCRATCH_0 = 6'h1e;
  localparam logic [5:0] IOD_NVM_CONTROL = 6'h1f;
  localparam logic [5:0] IOD_NVM_DATA = 6'h20;
  localparam logic [5:0] IOD_NVM_ADDRESS_LOW = 6'h21;
  localparam logic [5:0] IOD_NVM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] IOD_GENERAL_TIMER_CONTROL = 6'h23;
  localparam logic [5:0] IOD_TIMER0_CONTROL_A = 6'h24;
  localparam logic [5:0] IOD_TIMER0_CONTROL_B = 6'h25;
  localparam logic [5:0] IOD_TIMER0_COUNT = 6'h26;
  localparam logic [5:0] IOD_TIMER0_COMPARE_A = 6'h27;
  localparam logic [5:0] IOD_TIMER0_COMPARE_B = 6'h28;
  localparam logic [5:0] IOD_GENERAL_SCRATCH_1 = 6'h2a;
  localparam logic [5:0] IOD_GENERAL_SCRATCH_2 = 6'h2b;
  localparam logic [5:0] IOD_SERIAL_PERIPH_CONTROL = 6'h2c;
  localparam logic [5:0] IOD_SERIAL_PERIPH_STATUS = 6'h2d;
  localparam logic [5:0] IOD_SERIAL_PERIPH_DATA = 6'h2e;
  localparam logic [5:0] IOD_COMPARATOR_CONTROL_STATUS = 6'h30;
  localparam logic [5:0] IOD_SLEEP_CONTROL = 6'h33;
  localparam logic [5:0] IOD_RESET_CAUSE_STATUS = 6'h34;
  localparam logic [5:0] IOD_CORE_CONTROL = 6'h35;

  // Field masks: implemented bits per register class
  localparam logic [7:0] IOD_MASK_NONE = 8'h00;
  localparam logic [7:0] IOD_MASK_FULL = 8'hff;
  localparam logic [7:0] IOD_MASK_PORT_C = 8'h7f;
  localparam logic [7:0] IOD_MASK_TIMER0_FLAGS = 8'h07;
  localparam logic [7:0] IOD_MASK_TIMER1_FLAGS = 8'h27;
  localparam logic [7:0] IOD_MASK_TIMER2_FLAGS = 8'h07;
  localparam logic [7:0] IOD_MASK_PIN_CHANGE = 8'h07;
  localparam logic [7:0] IOD_MASK_EXT_IRQ = 8'h03;
  localparam logic [7:0] IOD_MASK_NVM_CONTROL = 8'h3f;
  localparam logic [7:0] IOD_MASK_GEN_TIMER = 8'h83;
  localparam logic [7:0] IOD_MASK_TIMER0_CTL_A = 8'hf3;
  localparam logic [7:0] IOD_MASK_TIMER0_CTL_B = 8'hcf;
  localparam logic [7:0] IOD_MASK_SPI_STATUS_RW = 8'h01;
  localparam logic [7:0] IOD_MASK_SPI_STATUS_RO = 8'hc0;
  localparam logic [7:0] IOD_MASK_COMP_RW = 8'hcf;
  localparam logic [7:0] IOD_MASK_COMP_RO = 8'h20;
  localparam logic [7:0] IOD_MASK_COMP_W1C = 8'h10;
  localparam logic [7:0] IOD_MASK_LOW_NIBBLE = 8'h0f;
  localparam logic [7:0] IOD_MASK_CORE_CTL = 8'h73;
  localparam logic [7:0] IOD_RESET_VALUE = 8'h00;
  localparam logic [7:0] IOD_BIT_ONE = 8'h01;

  // Request kinds, one-hot
  typedef enum logic [7:0] {
    IOD_IO_READ = 8'h01,
    IOD_IO_WRITE = 8'h02,
    IOD_DATA_READ = 8'h04,
    IOD_DATA_WRITE = 8'h08,
    IOD_SET_IO_BIT = 8'h10,
    IOD_CLEAR_IO_BIT = 8'h20,
    IOD_SKIP_IF_IO_BIT_SET = 8'h40,
    IOD_SKIP_IF_IO_BIT_CLEAR = 8'h80
  } iod_kind_t;

  // Decoder states, one-hot
  typedef enum logic [1:0] {
    IOD_ST_IDLE = 2'b01,
    IOD_ST_EXT_WAIT = 2'b10
  } iod_state_t;

  // Core request
  typedef struct packed {
    logic valid;
    iod_kind_t kind;
    logic [7:0] addr;
    logic [2:0] bitSel;
    logic [7:0] wdata;
  } iod_req_t;

  // Answer to the core
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic skip;
    logic refused;
  } iod_resp_t;

  // Extended I/O access forwarded outward
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iod_ext_t;

  // Port pin levels
  typedef struct packed {
    logic [7:0] port_b_output;
    logic [6:0] port_c_output;
    logic [7:0] port_d_output;
  } iod_pins_t;

endpackage

// *** bench/iod_checker.sv ***
// Assertions on the decoder's core, extended and register image ports.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module iod_checker
  import iod_pkg::*;
#(
  parameter int IO_LOCS = IOD_IO_LOCS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Core side
  input iod_req_t req,
  input iod_resp_t resp,
  // Far side and image
  input iod_ext_t ext,
  input wire logic [7:0] extRdata,
  input wire logic [63:0][7:0] hwSet,
  input wire logic [63:0][7:0] regImage
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Request classes from the one-hot kind
  wire logic isIo = req.valid && req.kind[1:0] != 2'b00;
  wire logic isData = req.valid && req.kind[3:2] != 2'b00;
  wire logic isBit = req.valid && req.kind[7:4] != 4'h0;
  io_range_a: assert property (isIo && req.addr >= 8'(IO_LOCS) |=> resp.valid && resp.refused)
    else $error("io access above top answered");
  bit_range_a: assert property (isBit && req.addr > IOD_BIT_TOP |=> resp.valid && resp.refused)
    else $error("bit access above low range answered");
  data_low_a: assert property (isData && req.addr < IOD_DATA_OFS |=> resp.valid && resp.refused)
    else $error("data access below offset answered");
  ext_fwd_a: assert property (isData && req.addr >= IOD_EXT_LO |=>
    (ext.read || ext.write) && ext.addr == $past(req.addr) && !resp.refused)
    else $error("extended access not forwarded");
  ext_ans_a: assert property (ext.read |=> resp.valid && resp.data == $past(extRdata))
    else $error("extended read answer wrong");
  data_ofs_a: assert property (req.valid && req.kind == IOD_DATA_WRITE &&
    req.addr == IOD_DATA_OFS + 8'(IOD_GENERAL_SCRATCH_0) |=> regImage[IOD_GENERAL_SCRATCH_0] == $past(req.wdata))
    else $error("data store at offset missed");
  set_bit_a: assert property (req.valid && req.kind == IOD_SET_IO_BIT && req.addr == 8'(IOD_PORT_D_OUTPUT)
    |=> regImage[IOD_PORT_D_OUTPUT] == ($past(regImage[IOD_PORT_D_OUTPUT]) | (8'h01 << $past(req.bitSel))))
    else $error("bit set result wrong");
  bit_skip_a: assert property (isBit && req.kind[7:6] != 2'b00 && req.addr <= IOD_BIT_TOP
    |=> resp.valid && resp.skip == ($past(regImage[req.addr[5:0]][req.bitSel]) ^ $past(req.kind[7])))
    else $error("bit test skip wrong");
  flag_clear_a: assert property (isIo && req.kind == IOD_IO_WRITE && req.addr == 8'(IOD_TIMER0_FLAGS) |=>
    regImage[21] == ((($past(regImage[21]) & ~$past(req.wdata)) | $past(hwSet[21])) & IOD_MASK_TIMER0_FLAGS))
    else $error("flag clear wrong");
  reserved_read_a: assert property (isIo && req.kind == IOD_IO_READ && req.addr inside {8'h29, 8'h2f, [8'h0c:8'h14]}
    |=> resp.valid && resp.data == 8'h00)
    else $error("reserved read not zero");
endmodule
bind iod_io_register_space_decoder iod_checker #(.IO_LOCS(IO_LOCS)) chk (.core_clk(core_clk), .rstn(rstn),
  .req(req), .resp(resp), .ext(ext), .extRdata(extRdata), .hwSet(hwSet), .regImage(regImage));

// *** bench/iod_ext_model.sv ***
// Extended register store standing behind the forwarded data access.
// Assumes read data is taken in the cycle the read pulse is high.
`timescale 1ns/1ps
module iod_ext_model
  import iod_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Forwarded access
  input iod_ext_t ext,
  output logic [7:0] extRdata
);
  logic [7:0] storeMem [256];
  logic [7:0] last_q;
  // Store forwarded writes
  always_ff @(posedge core_clk) begin
    if (ext.write) begin
      storeMem[ext.addr] <= ext.wdata;
    end
  end
  // Data only during a read, inverted history otherwise
  assign extRdata = ext.read ? storeMem[ext.addr] : ~last_q;
  // Last value on the data lines
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 8'h00;
    end else begin
      last_q <= extRdata;
    end
  end
endmodule

// *** bench/test_io_register_space_decoder.sv ***
// Self-checking bench for the low I/O register space decoder.
// Assumes one request at a time, answered within a few cycles.
`timescale 1ns/1ps
module test_io_register_space_decoder
  import iod_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  iod_req_t req = '0;
  iod_resp_t resp;
  iod_ext_t ext;
  logic [7:0] extRdata;
  iod_pins_t pinsIn = '{8'ha5, 7'h3c, 8'h96};
  logic [63:0][7:0] hwSet = '0;
  logic [63:0][7:0] hwLevel = '0;
  logic [63:0][7:0] regImage;
  logic [7:0] rd;
  logic sk;
  logic rf;
  int fails = 0;
  int n_compared = 0;
  // Design and far-side model
  iod_io_register_space_decoder #(.IO_LOCS(64)) dut (.core_clk(core_clk), .rstn(rstn), .req(req), .resp(resp),
    .ext(ext), .extRdata(extRdata), .pinsIn(pinsIn), .hwSet(hwSet), .hwLevel(hwLevel), .regImage(regImage));
  iod_ext_model extModel (.core_clk(core_clk), .rstn(rstn), .ext(ext), .extRdata(extRdata));
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  // Verdict and end of run
  task automatic conclude();
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  // One request, bounded wait for the answer
  task automatic op(input iod_kind_t k, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w);
    int i;
    @(negedge core_clk);
    req = '{1'b1, k, a, b, w};
    @(negedge core_clk);
    req.valid = 1'b0;
    for (i = 0; i < 4 && resp.valid !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    if (i == 4) begin
      fails++;
      conclude();
    end
    rd = resp.data;
    sk = resp.skip;
    rf = resp.refused;
  endtask
  // Accepted access with expected data
  task automatic act(input iod_kind_t k, input logic [7:0] a, input logic [7:0] w, input logic [7:0] exp);
    op(k, a, 3'h0, w);
    chk({7'h00, rf}, 8'h00);
    chk(rd, exp);
  endtask
  // Request expected to be refused
  task automatic rej(input iod_kind_t k, input logic [7:0] a);
    op(k, a, 3'h0, 8'h00);
    chk({7'h00, rf}, 8'h01);
  endtask
  // Accepted bit set or clear
  task automatic bop(input iod_kind_t k, input logic [7:0] a, input logic [2:0] b);
    op(k, a, b, 8'h00);
    chk({7'h00, rf}, 8'h00);
  endtask
  // Image cleared by reset
  task automatic t_reset();
    for (int i = 0; i < 64; i++) begin
      chk(regImage[i], 8'h00);
    end
  endtask
  // Dedicated access, top of range, a reserved place, pins
  task automatic t_io();
    act(IOD_IO_WRITE, 8'h05, 8'haa, 8'h00);
    act(IOD_IO_READ, 8'h05, 8'h00, 8'haa);
    act(IOD_IO_WRITE, 8'h08, 8'hff, 8'h00);
    act(IOD_IO_READ, 8'h08, 8'h00, 8'h7f);
    act(IOD_IO_READ, 8'h29, 8'h00, 8'h00); // Reserved place only read
    act(IOD_IO_WRITE, 8'h03, 8'h00, 8'h00);
    act(IOD_IO_READ, 8'h03, 8'h00, 8'ha5); // Pin input ignores writes
    op(IOD_IO_READ, 8'h3f, 3'h0, 8'h00);
    chk({7'h00, rf}, 8'h00);
    rej(IOD_IO_READ, 8'h40);
    rej(IOD_IO_WRITE, 8'h40);
  endtask
  // Load and store at the offset
  task automatic t_data();
    act(IOD_DATA_READ, 8'h25, 8'h00, 8'haa);
    act(IOD_DATA_READ, 8'h26, 8'h00, 8'h3c);
    act(IOD_DATA_WRITE, 8'h3e, 8'h5a, 8'h00);
    act(IOD_IO_READ, 8'h1e, 8'h00, 8'h5a);
    rej(IOD_DATA_READ, 8'h1f);
  endtask
  // Extended range at both ends
  task automatic t_ext();
    logic [7:0] a;
    for (int i = 0; i < 2; i++) begin
      a = (i == 1) ? 8'hff : 8'h60;
      act(IOD_DATA_WRITE, a, a ^ 8'h3c, 8'h00);
      act(IOD_DATA_READ, a, 8'h00, a ^ 8'h3c);
    end
    rej(IOD_IO_WRITE, 8'h60);
  endtask
  // Bit set, clear and test
  task automatic t_bits();
    for (int i = 0; i < 8; i++) begin
      bop(IOD_SET_IO_BIT, 8'h0b, i[2:0]);
    end
    bop(IOD_CLEAR_IO_BIT, 8'h0b, 3'h3);
    act(IOD_IO_READ, 8'h0b, 8'h00, 8'hf7);
    for (int j = 0; j < 4; j++) begin
      op(j[1] ? IOD_SKIP_IF_IO_BIT_CLEAR : IOD_SKIP_IF_IO_BIT_SET, 8'h0b, j[0] ? 3'h2 : 3'h3, 8'h00);
      chk({7'h00, sk}, {7'h00, j[0] ^ j[1]});
    end
    rej(IOD_SET_IO_BIT, 8'h20);
    bop(IOD_SET_IO_BIT, 8'h1f, 3'h5);
    act(IOD_IO_READ, 8'h1f, 8'h00, 8'h20);
  endtask
  // Write-one-to-clear flags
  task automatic t_flags();
    hwSet[21] = 8'hff;
    @(negedge core_clk);
    hwSet[21] = 8'h00;
    act(IOD_IO_READ, 8'h15, 8'h00, 8'h07);
    act(IOD_IO_WRITE, 8'h15, 8'h00, 8'h00);
    act(IOD_IO_READ, 8'h15, 8'h00, 8'h07);
    act(IOD_IO_WRITE, 8'h15, 8'h01, 8'h00); // Clears bit 0 only, bits 1 and 2 stay set
    act(IOD_IO_READ, 8'h15, 8'h00, 8'h06);
    bop(IOD_SET_IO_BIT, 8'h15, 3'h1);
    act(IOD_IO_READ, 8'h15, 8'h00, 8'h04);
    bop(IOD_CLEAR_IO_BIT, 8'h15, 3'h2);
    act(IOD_IO_READ, 8'h15, 8'h00, 8'h04);
    // Comparator status: level bit follows hardware, not writes
    act(IOD_IO_WRITE, 8'h30, 8'hff, 8'h00);
    act(IOD_IO_READ, 8'h30, 8'h00, 8'hcf);
    hwLevel[48] = 8'hff;
    act(IOD_IO_READ, 8'h30, 8'h00, 8'hef);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    t_reset();
    t_io();
    t_data();
    t_ext();
    t_bits();
    t_flags();
    conclude();
  end
endmodule
